//--- src/pief_top.sv
// peripheral interrupt enable, request flag and gating logic behind a wishbone slave
//
// Contract
// (R1) enable1 bit 7: timer1 gate acquisition enable
// (R2) enable1 bits 6..4: adc, rx, tx enables
// (R3) enable1 bits 3..0: sync, capcmp1, t2, t1 enables
// (R4) enable2 bits 7..3: osc, cmp2, cmp1, eeprom, collision
// (R5) enable2 bits 2..0 ignore writes, read zero
// (R6) enable bits read/write, clear on reset
// (R7) no request without peripheral group enable; irq_o from status and mask is not gated by it
// (R8) flags set regardless of any enable
// (R9) software clears flags before enabling sources
// (R10) request1 bits 7 and 0: t1 gate, overflow
// (R11) request1 bits 6,3,2,1 software read/write
// (R12) request1 bits 5,4 read-only; reset zero
// (R13) enabled irq with global enable: vector, clear enable
// (R14) enabled pending irq wakes, ignoring global enable
// (R15) request is OR of flag AND enable, gated
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module pief_top
  import pief_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire pief_wb_req_type wb_req_i,
  output logic                 wb_ack_o,
  output logic [31:0]          wb_dat_o,
  input  wire logic [7:0]      evt_i,
  input  wire logic [7:0]      req2_flags_i,
  input  wire logic            irq_taken_i,
  input  wire logic            irq_return_i,
  output logic                 periph_irq_o,
  output logic                 vector_req_o,
  output logic                 wake_o,
  output logic                 irq_o
);

  logic [7:0] en1_q, en1_d;
  logic [7:0] en2_q, en2_d;
  logic [7:0] req1_q, req1_d;
  logic       gie_q, gie_d;
  logic       peripheral_group_enable_q, peripheral_group_enable_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] mask_q, mask_d;
  logic       ack_q, ack_d;
  logic [7:0] rdat_q, rdat_d;
  logic       pirq_q, pirq_d;
  logic       vec_q, vec_d;
  logic       wake_q, wake_d;
  logic       irq_q, irq_d;

  logic       wr;
  logic [7:0] wdat;
  logic [7:0] req1_sw;
  logic [7:0] pend;
  logic [7:0] rsel;

  // writes land on the edge where the master sees ack, so both agree on timing
  assign wr   = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_q & wb_req_i.sel[0];
  assign wdat = wb_req_i.dat[7:0];

  // ---------------- enable registers
  always_comb begin
    en1_d = en1_q;
    en2_d = en2_q;
    if (wr && pief_hit(wb_req_i.adr, PIEF_OFS_EN1)) begin
      en1_d = wdat; // [R1] [R2] [R3] [R6]
    end
    if (wr && pief_hit(wb_req_i.adr, PIEF_OFS_EN2)) begin
      en2_d = wdat & PIEF_EN2_IMPL; // [R4] [R5] [R6]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en1_q <= PIEF_RST_VAL; // [R6]
      en2_q <= PIEF_RST_VAL; // [R6]
    end else begin
      en1_q <= en1_d;
      en2_q <= en2_d;
    end
  end

  // ---------------- request flags
  // a source event in the same cycle as a software clear wins
  always_comb begin
    req1_sw = req1_q;
    if (wr && pief_hit(wb_req_i.adr, PIEF_OFS_REQ1)) begin
      req1_sw = wdat; // [R10] [R11]
    end
    // rx/tx flags track their source level, software cannot touch them
    req1_d = ((req1_sw | evt_i) & PIEF_REQ1_RW) | (evt_i & PIEF_REQ1_RO); // [R8] [R12]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req1_q <= PIEF_RST_VAL; // [R12]
    end else begin
      req1_q <= req1_d;
    end
  end

  // ---------------- core control: global and group enables
  always_comb begin
    gie_d  = gie_q;
    peripheral_group_enable_d = peripheral_group_enable_q;
    if (wr && pief_hit(wb_req_i.adr, PIEF_OFS_CTRL)) begin
      gie_d  = wdat[PIEF_GIE_BIT];
      peripheral_group_enable_d = wdat[PIEF_PERIPHERAL_GROUP_ENABLE_BIT];
    end
    if (irq_return_i) begin
      gie_d = 1'b1;
    end
    // taking the vector blocks nesting until the return
    if (irq_taken_i) begin
      gie_d = 1'b0; // [R13]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gie_q  <= 1'b0;
      peripheral_group_enable_q <= 1'b0;
    end else begin
      gie_q  <= gie_d;
      peripheral_group_enable_q <= peripheral_group_enable_d;
    end
  end

  // ---------------- request gating toward the core
  // request2 flags live outside; only their enables are held here
  always_comb begin
    pend   = (req1_q & en1_q) | (req2_flags_i & en2_q); // [R15]
    pirq_d = (|pend) & peripheral_group_enable_q; // [R7] [R15]
    vec_d  = pirq_d & gie_q & ~irq_taken_i; // [R13]
    wake_d = pirq_d; // [R14]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pirq_q <= 1'b0;
      vec_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      pirq_q <= pirq_d;
      vec_q  <= vec_d;
      wake_q <= wake_d;
    end
  end

  // ---------------- sticky event status, mask and interrupt line
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr && pief_hit(wb_req_i.adr, PIEF_OFS_STAT)) begin
      stat_d = stat_q & ~wdat;
    end
    if (wr && pief_hit(wb_req_i.adr, PIEF_OFS_MASK)) begin
      mask_d = wdat;
    end
    // rising flags set status after the clear so set wins
    stat_d = stat_d | (req1_d & ~req1_q);
    irq_d  = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= PIEF_RST_VAL;
      mask_q <= PIEF_RST_VAL;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

  // ---------------- wishbone answer: one wait state, unmapped reads zero
  always_comb begin
    rsel = 8'h00;
    if (pief_hit(wb_req_i.adr, PIEF_OFS_EN1)) begin
      rsel = en1_q;
    end else if (pief_hit(wb_req_i.adr, PIEF_OFS_EN2)) begin
      rsel = en2_q & PIEF_EN2_IMPL; // [R5]
    end else if (pief_hit(wb_req_i.adr, PIEF_OFS_REQ1)) begin
      rsel = req1_q;
    end else if (pief_hit(wb_req_i.adr, PIEF_OFS_CTRL)) begin
      rsel = {gie_q, peripheral_group_enable_q, 6'h00};
    end else if (pief_hit(wb_req_i.adr, PIEF_OFS_STAT)) begin
      rsel = stat_q;
    end else if (pief_hit(wb_req_i.adr, PIEF_OFS_MASK)) begin
      rsel = mask_q;
    end
    ack_d  = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
    rdat_d = ack_d ? rsel : 8'h00;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = {24'h000000, rdat_q};
  assign periph_irq_o = pirq_q;
  assign vector_req_o = vec_q;
  assign wake_o       = wake_q;
  assign irq_o        = irq_q;

  // ---------------- checks
  chk_en1_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R1] [R2] [R3]
    wr && pief_hit(wb_req_i.adr, PIEF_OFS_EN1) |=> en1_q == $past(wdat))
    else $error("enable1 did not take written value");

  chk_en2_low_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R4] [R5]
    wr && pief_hit(wb_req_i.adr, PIEF_OFS_EN2)
    |=> en2_q == ($past(wdat) & 8'hF8) && wb_dat_o[2:0] == 3'h0)
    else $error("enable2 low bits or upper bits wrong after write");

  chk_reset_clear: assert property (@(posedge clk_i) // [R6] [R12]
    rst_i |=> en1_q == 8'h00 && en2_q == 8'h00 && req1_q == 8'h00 && !irq_o)
    else $error("registers not cleared by reset");

  chk_group_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    !peripheral_group_enable_q |=> !periph_irq_o)
    else $error("peripheral request without group enable");

  chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // [R8] [R11]
    (evt_i & 8'hCF) != 8'h00 |=> (req1_q & $past(evt_i & 8'hCF)) == $past(evt_i & 8'hCF))
    else $error("event failed to set its flag");

  chk_ro_bits: assert property (@(posedge clk_i) disable iff (rst_i) // [R12] [R10]
    wr && pief_hit(wb_req_i.adr, PIEF_OFS_REQ1) |=> req1_q[5:4] == $past(evt_i[5:4]))
    else $error("read-only flag changed by software");

  chk_gie_taken: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    irq_taken_i |=> !gie_q ##1 !vector_req_o)
    else $error("global enable not cleared on vector");

  chk_vector_needs: assert property (@(posedge clk_i) disable iff (rst_i) // [R13] [R14]
    vector_req_o |-> wake_o && periph_irq_o)
    else $error("vector without wake and peripheral request");

  chk_wake_nogie: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    !gie_q && peripheral_group_enable_q && ((req1_q & en1_q) != 8'h00) |=> wake_o)
    else $error("no wake with global enable clear");

  chk_or_and: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    ##1 periph_irq_o == $past(peripheral_group_enable_q && ((req1_q & en1_q) | (req2_flags_i & en2_q)) != 8'h00))
    else $error("peripheral request not flag-and-enable reduction");

  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

//--- shared/pief_pkg.sv
// constants, register map and bus carrier for the peripheral irq enable/flag block
package pief_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] PIEF_OFS_EN1  = 8'h00;
  localparam logic [7:0] PIEF_OFS_EN2  = 8'h04;
  localparam logic [7:0] PIEF_OFS_REQ1 = 8'h08;
  localparam logic [7:0] PIEF_OFS_CTRL = 8'h0C;
  localparam logic [7:0] PIEF_OFS_STAT = 8'h10;
  localparam logic [7:0] PIEF_OFS_MASK = 8'h14;

  // value of every register after any reset
  localparam logic [7:0] PIEF_RST_VAL = 8'h00;

  // implemented bits of the second enable register
  localparam logic [7:0] PIEF_EN2_IMPL = 8'hF8;

  // first request register: software-writable and read-only bits
  localparam logic [7:0] PIEF_REQ1_RW = 8'hCF;
  localparam logic [7:0] PIEF_REQ1_RO = 8'h30;

  // bit positions in core_irq_control
  localparam int unsigned PIEF_GIE_BIT  = 7;
  localparam int unsigned PIEF_PERIPHERAL_GROUP_ENABLE_BIT = 6;

  // source positions in enable 1 / request 1
  localparam int unsigned PIEF_T1_GATE = 7;
  localparam int unsigned PIEF_ADC     = 6;
  localparam int unsigned PIEF_RX      = 5;
  localparam int unsigned PIEF_TX      = 4;
  localparam int unsigned PIEF_SYNC    = 3;
  localparam int unsigned PIEF_CAPCMP1 = 2;
  localparam int unsigned PIEF_T2      = 1;
  localparam int unsigned PIEF_T1_OVF  = 0;

  // source positions in enable 2
  localparam int unsigned PIEF_OSC_FAIL = 7;
  localparam int unsigned PIEF_CMP2     = 6;
  localparam int unsigned PIEF_CMP1     = 5;
  localparam int unsigned PIEF_EE_DONE  = 4;
  localparam int unsigned PIEF_BUS_COLL = 3;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pief_wb_req_type;

  function automatic logic pief_hit(input logic [7:0] adr, input logic [7:0] ofs);
    pief_hit = (adr[7:2] == ofs[7:2]);
  endfunction

endpackage

//--- dv/pief_core_model.sv
// core and event-source stand-in facing the irq block
`timescale 1ns/10ps
module pief_core_model
  import pief_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] evt_cmd_i,
  input  wire logic       slow_i,
  input  wire logic       ret_cmd_i,
  input  wire logic       vector_req_i,
  output logic [7:0]      evt_o,
  output logic            taken_o,
  output logic            ret_o
);
  logic [1:0] wait_q;
  // events pass one clock late, like a peripheral flop
  always_ff @(posedge clk_i) begin
    evt_o <= evt_cmd_i;
    ret_o <= ret_cmd_i;
    if (rst_i) begin
      wait_q  <= 2'h0;
      taken_o <= 1'b0;
    end else begin
      taken_o <= 1'b0;
      // request still high at the taking edge, so skip it once
      if (vector_req_i && !taken_o) begin
        wait_q <= wait_q + 2'h1;
        if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
          taken_o <= 1'b1;
          wait_q  <= 2'h0;
        end
      end
    end
  end
endmodule

//--- dv/testbench.sv
// self-checking bench for the peripheral irq enable/flag block
`timescale 1ns/10ps
module testbench;
  import pief_pkg::*;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  pief_wb_req_type req = '0;
  logic            wb_ack_o, periph_irq_o, vector_req_o, wake_o, irq_o;
  logic [31:0]     wb_dat_o, v;
  logic [7:0]      evt_i, evt_cmd = '0, req2 = '0;
  logic            taken, ret, ret_cmd = 1'b0, slow = 1'b0;
  logic [7:0]      m_en1, m_en2, m_st, m_mk;
  int              error_cnt = 0, samples_checked = 0;
  always #12.5 clk_i = ~clk_i;
  pief_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .evt_i(evt_i), .req2_flags_i(req2), .irq_taken_i(taken),
    .irq_return_i(ret), .periph_irq_o(periph_irq_o), .vector_req_o(vector_req_o),
    .wake_o(wake_o), .irq_o(irq_o));
  pief_core_model core (.clk_i(clk_i), .rst_i(rst_i), .evt_cmd_i(evt_cmd), .slow_i(slow),
    .ret_cmd_i(ret_cmd), .vector_req_i(vector_req_o), .evt_o(evt_i), .taken_o(taken),
    .ret_o(ret));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ack and data are read at the rising edge itself, before its updates land
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      report_and_stop;
    end
    v = wb_dat_o;
    req <= '0;
  endtask
  initial begin
    void'($urandom(32'h2efd84fe));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      wb(1'b0, 8'(a * 4), 8'h00);
      chk(v, 32'h0);
    end
    $display("reset test done");
    m_en1 = 8'($urandom) | 8'h01;
    m_en2 = 8'($urandom) | 8'h0F;
    wb(1'b1, PIEF_OFS_EN1, m_en1);
    wb(1'b1, PIEF_OFS_EN2, m_en2);
    wb(1'b1, 8'h18, 8'hFF);
    wb(1'b0, PIEF_OFS_EN1, 8'h00);
    chk(v, {24'h0, m_en1});
    wb(1'b0, PIEF_OFS_EN2, 8'h00);
    chk(v, {24'h0, m_en2 & 8'hF8});
    wb(1'b1, PIEF_OFS_REQ1, 8'hFF);
    wb(1'b0, PIEF_OFS_REQ1, 8'h00);
    chk(v, 32'hCF);
    chk(periph_irq_o, 1'b0);
    wb(1'b1, PIEF_OFS_REQ1, 8'h00);
    wb(1'b1, PIEF_OFS_STAT, 8'hFF);
    m_mk = 8'($urandom) | 8'h10;
    wb(1'b1, PIEF_OFS_MASK, m_mk);
    $display("register test done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      evt_cmd <= 8'h01 << k;
      @(posedge clk_i);
      evt_cmd <= 8'h00;
    end
    m_st = 8'hFF;
    wb(1'b0, PIEF_OFS_REQ1, 8'h00);
    chk(v, 32'hCF);
    wb(1'b0, PIEF_OFS_STAT, 8'h00);
    chk(v, {24'h0, m_st});
    chk({periph_irq_o, wake_o, irq_o}, {2'b00, |(m_st & m_mk)});
    wb(1'b1, PIEF_OFS_STAT, 8'h1F);
    m_st = m_st & 8'hE0;
    wb(1'b1, PIEF_OFS_CTRL, 8'h40);
    repeat (2) @(negedge clk_i);
    chk({periph_irq_o, wake_o, irq_o}, {2'b11, |(m_st & m_mk)});
    $display("event test done");
    slow = 1'($urandom);
    wb(1'b1, PIEF_OFS_CTRL, 8'hC0);
    for (int n = 0; n < 20 && vector_req_o !== 1'b1; n++)
      @(negedge clk_i);
    chk(vector_req_o, 1'b1);
    repeat (8) @(posedge clk_i);
    wb(1'b0, PIEF_OFS_CTRL, 8'h00);
    chk(v, 32'h40);
    wb(1'b1, PIEF_OFS_REQ1, 8'h00);
    repeat (2) @(negedge clk_i);
    chk({periph_irq_o, wake_o}, 2'b00);
    @(posedge clk_i);
    req2 <= 8'h08;
    repeat (2) @(negedge clk_i);
    chk({periph_irq_o, vector_req_o}, 2'b10);
    @(posedge clk_i);
    req2 <= 8'h00;
    ret_cmd <= 1'b1;
    @(posedge clk_i);
    ret_cmd <= 1'b0;
    wb(1'b0, PIEF_OFS_CTRL, 8'h00);
    chk(v, 32'hC0);
    $display("vector test done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, PIEF_OFS_EN1, 8'h00);
    chk(v, 32'h0);
    $display("second reset test done");
    report_and_stop;
  end
endmodule
